// ===== dv/dmx_exec_asserts.sv
// dmx_exec_asserts: port checks for dmx_exec
// assumes a bind onto dmx_exec
`timescale 1ns/10ps
module dmx_exec_asserts
  import dmx_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] bank_select_o,
  input wire logic [7:0] work_o,
  input wire logic illegal_dest_o,
  input wire logic [7:0] mem_rdata_o
);
  // ==========
  // checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [11:0] f = instr_i[11:0];
  wire bad = f == DMX_PCL_ADDR || f >= DMX_RET_STACK_TOP_LOW_ADDR;
  wire vw = instr_valid_i && f == DMX_WORK_ADDR;
  sequence mv_s(s, d);
    instr_valid_i && instr_i[15:12] == DMX_OP_MOVE_SRC && s ##1 instr_valid_i && instr_i[15:12] == DMX_OP_MOVE_DST && d;
  endsequence
  bank_hi_a: assert property (bank_select_o[7:4] == DMX_BANK_MASK_HI) else $error("bank high set");
  bank_load_a: assert property (instr_valid_i && instr_i[15:8] == DMX_OP_BANK_LIT
    |=> bank_select_o == {4'h0, $past(instr_i[3:0])}) else $error("bank load wrong");
  work_load_a: assert property (instr_valid_i && instr_i[15:8] == DMX_OP_WORK_LIT
    |=> work_o == $past(instr_i[7:0])) else $error("work load wrong");
  store_keep_a: assert property (instr_valid_i && instr_i[15:9] == DMX_OP_STORE_WORK
    |=> $stable(work_o) && $stable(bank_select_o)) else $error("store changed regs");
  move_bad_a: assert property (mv_s(1'b1, bad) |=> illegal_dest_o) else $error("bad dest missed");
  move_ok_a: assert property (mv_s(1'b1, !bad) |=> !illegal_dest_o) else $error("good dest flagged");
  work_dst_a: assert property (mv_s(1'b1, vw) |=> work_o == mem_rdata_o) else $error("work dest wrong");
  work_src_a: assert property (mv_s(vw, !bad && !vw) |=> mem_rdata_o == work_o) else $error("work src wrong");
endmodule
bind dmx_exec dmx_exec_asserts u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .bank_select_o(bank_select_o), .work_o(work_o), .illegal_dest_o(illegal_dest_o),
  .mem_rdata_o(mem_rdata_o));

// ===== dv/dmx_exec_test.sv
// dmx_exec_test: random model check of dmx_exec
// assumes dmx_pkg and the bound checker
`timescale 1ns/10ps
module dmx_exec_test import dmx_pkg::*;;
  logic core_clk_i = 0, rst_n_i = 0, v = 0, ext = 0, bad, eill = 0, rdy;
  logic [15:0] ins = 0;
  logic [11:0] base = 0, src = 0, la = 0, d;
  logic [7:0] bank, work, rd, eb = 0, ew = 0, er = 0;
  logic [7:0] mem [int];
  int num_errors = 0, samples_checked = 0;
  dmx_exec dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(v), .instr_i(ins),
    .ext_set_en_i(ext), .index_base_i(base), .ready_o(rdy), .bank_select_o(bank), .work_o(work),
    .illegal_dest_o(bad), .mem_rdata_o(rd));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // issue one word, check the previous one, then update the model
  task automatic op(logic [15:0] w);
    logic e;
    logic [11:0] b, a;
    e = 1'($urandom);
    b = 12'($urandom);
    @(posedge core_clk_i);
    v <= 1;
    ins <= w;
    ext <= e;
    base <= b;
    #1;
    chk(bank, eb);
    chk(work, ew);
    chk({7'h0, bad}, {7'h0, eill});
    chk(rd, er);
    chk({7'h0, rdy}, 8'h01);
    a = w[8] ? {eb[3:0], w[7:0]} : (e && w[7:0] <= DMX_INDEX_LIMIT) ? b + 12'(w[7:0])
      : {{4{w[7:0] >= DMX_ACCESS_SPLIT}}, w[7:0]};
    if (w[15:8] == DMX_OP_BANK_LIT) eb = w[7:0] & 8'h0F;
    if (w[15:8] == DMX_OP_WORK_LIT) ew = w[7:0];
    if (w[15:9] == DMX_OP_STORE_WORK) begin
      la = a;
      mem[a] = ew;
    end
    if (w[15:12] == DMX_OP_MOVE_SRC) src = w[11:0];
    if (w[15:12] == DMX_OP_MOVE_DST) begin
      eill = w[11:0] == DMX_PCL_ADDR || w[11:0] >= DMX_RET_STACK_TOP_LOW_ADDR;
      if (!eill) begin
        er = src == DMX_WORK_ADDR ? ew : mem[src];
        mem[w[11:0]] = er;
        if (w[11:0] == DMX_WORK_ADDR) ew = er;
      end
    end
  endtask
  initial begin
    void'($urandom(13));
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1;
    for (int i = 0; i < 300; i++) begin
      d = i % 4 == 1 ? DMX_WORK_ADDR : i % 4 != 2 ? 12'($urandom)
        : i % 8 == 2 ? DMX_PCL_ADDR : DMX_RET_STACK_TOP_LOW_ADDR + 12'(i % 3);
      op({DMX_OP_BANK_LIT, 8'($urandom)});
      op({DMX_OP_WORK_LIT, 8'($urandom)});
      op({DMX_OP_STORE_WORK, 9'($urandom)});
      op({DMX_OP_MOVE_SRC, la});
      // foreign word while the move waits
      if (i % 3 == 0) op(16'h0000);
      op({DMX_OP_MOVE_DST, d});
      op({DMX_OP_MOVE_SRC, DMX_WORK_ADDR});
      op({DMX_OP_MOVE_DST, 12'($urandom) & 12'hEFF});
      // source byte kept after the copy
      if (i % 3 == 1) begin
        op({DMX_OP_MOVE_SRC, la});
        op({DMX_OP_MOVE_DST, DMX_WORK_ADDR});
      end
    end
    op(16'h0000);
    $display("test random moves done");
    close_out();
  end
  initial begin
    repeat (5000) @(posedge core_clk_i);
    num_errors++;
    close_out();
  end
endmodule

// ===== hw/dmx_data_mem.sv
// dmx_data_mem: data-space byte memory, registered read port
// assumes one write and one read per clock
`timescale 1ns/10ps
module dmx_data_mem
  import dmx_pkg::*;
#(
  parameter int ADDR_W = DMX_ADDR_W,
  parameter int DEPTH = DMX_DEPTH
) (
  input wire logic core_clk_i,
  input wire dmx_mem_s mem_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_reg [DEPTH];
  always_ff @(posedge core_clk_i) begin
    if (mem_i.we) begin
      mem_reg[mem_i.waddr[ADDR_W-1:0]] <= mem_i.wdata;
    end
    rdata_o <= mem_reg[mem_i.raddr[ADDR_W-1:0]];
  end
endmodule

// ===== hw/dmx_exec.sv
// dmx_exec: executes data-move instructions against the data space
// assumes one instruction word per cycle while ready_o is high
// Function
// - move copies the source byte to the destination, source untouched
// - move source reaches any 12-bit address, 000h to FFFh
// - move destination reaches any 12-bit address except PCL and the three return stack top bytes, ignoring bank select
// - work register, at its data address, may be move source or destination
// - bank literal load writes the literal's low nibble into bank select
// - bank select upper nibble always reads zero after bank load
// - work literal load places literal in work register, one cycle
// - access bit zero picks access bank, one uses bank select
// - access bit zero with extension: addresses up to 95 indexed
`timescale 1ns/10ps
module dmx_exec
  import dmx_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [11:0] index_base_i,
  output logic ready_o,
  output logic [7:0] bank_select_o,
  output logic [7:0] work_o,
  output logic illegal_dest_o,
  output logic [7:0] mem_rdata_o
);
  // ==================================================
  // state and datapath signals
  localparam int PROT_N = 4;
  localparam logic [11:0] PROT_ADDR [PROT_N] = '{
    DMX_PCL_ADDR,
    DMX_RET_STACK_TOP_LOW_ADDR,
    DMX_RET_STACK_TOP_HIGH_ADDR,
    DMX_RET_STACK_TOP_UPPER_ADDR
  };
  dmx_state_s cur_reg;
  dmx_state_s cur_next;
  dmx_mem_s mem;
  logic [7:0] rdata;
  logic [11:0] file_addr;
  logic [7:0] fsel;
  logic [7:0] src_byte;
  logic move_src_is_work;
  logic [11:0] move_src_addr;
  logic [11:0] banked_addr;
  logic [11:0] access_addr;
  logic [11:0] indexed_addr;
  logic use_indexed;
  logic [11:0] dst_addr;
  logic dst_is_work;
  logic [PROT_N-1:0] dst_hit;
  logic dst_protected;
  logic is_bank_lit;
  logic is_work_lit;
  logic is_store_work;
  logic is_move_src;
  logic is_move_dst;

  // ==================================================
  // data space
  dmx_data_mem #(
    .ADDR_W(DMX_ADDR_W),
    .DEPTH(DMX_DEPTH)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .mem_i(mem),
    .rdata_o(rdata)
  );

  // ==================================================
  // opcode decode
  always_comb begin
    is_bank_lit = 1'b0;
    is_work_lit = 1'b0;
    is_store_work = 1'b0;
    is_move_src = 1'b0;
    is_move_dst = 1'b0;
    if (instr_valid_i) begin
      case (instr_i[15:12])
        DMX_OP_MOVE_SRC: begin
          is_move_src = 1'b1;
        end
        DMX_OP_MOVE_DST: begin
          is_move_dst = 1'b1;
        end
        default: begin
          is_bank_lit = (instr_i[15:8] == DMX_OP_BANK_LIT);
          is_work_lit = (instr_i[15:8] == DMX_OP_WORK_LIT);
          is_store_work = (instr_i[15:9] == DMX_OP_STORE_WORK);
        end
      endcase
    end
  end

  // ==================================================
  // file address forming
  always_comb begin
    fsel = instr_i[7:0];
    banked_addr = {cur_reg.bank_select_reg[3:0], fsel};
    if (fsel < DMX_ACCESS_SPLIT) begin
      access_addr = {4'h0, fsel};
    end else begin
      access_addr = {DMX_ACCESS_HI_BANK, fsel};
    end
    use_indexed = ext_set_en_i && (fsel <= DMX_INDEX_LIMIT);
    indexed_addr = 12'(index_base_i + {4'h0, fsel});
    if (instr_i[DMX_ABIT_POS]) begin
      file_addr = banked_addr;
    end else if (use_indexed) begin
      file_addr = indexed_addr;
    end else begin
      file_addr = access_addr;
    end
  end

  // ==================================================
  // move operands
  // full 12-bit operands, bank ignored
  assign dst_addr = instr_i[11:0];
  always_comb begin
    if (cur_reg.state == DMX_MOVE_WAIT) begin
      move_src_addr = cur_reg.move_src;
    end else begin
      move_src_addr = instr_i[11:0];
    end
  end
  assign move_src_is_work = (cur_reg.move_src == DMX_WORK_ADDR);
  assign dst_is_work = (dst_addr == DMX_WORK_ADDR);
  always_comb begin
    if (move_src_is_work) begin
      src_byte = cur_reg.work_reg;
    end else begin
      src_byte = rdata;
    end
  end

  // ==================================================
  // protected destinations
  // match against each protected byte
  for (genvar gi = 0; gi < PROT_N; gi++) begin : g_prot
    assign dst_hit[gi] = (dst_addr == PROT_ADDR[gi]);
  end
  assign dst_protected = |dst_hit;

  // ==================================================
  // execute
  always_comb begin
    cur_next = cur_reg;
    mem = '0;
    // source read held through the wait
    mem.raddr = move_src_addr;
    case (cur_reg.state)
      DMX_FETCH: begin
        if (is_bank_lit) begin
          cur_next.bank_select_reg = {DMX_BANK_MASK_HI, instr_i[3:0]};
        end else if (is_work_lit) begin
          cur_next.work_reg = instr_i[7:0];
        end else if (is_store_work) begin
          mem.we = 1'b1;
          mem.waddr = file_addr;
          mem.wdata = cur_reg.work_reg;
        end else if (is_move_src) begin
          cur_next.move_src = instr_i[11:0];
          cur_next.state = DMX_MOVE_WAIT;
        end else begin
          // unknown words change nothing
          cur_next.state = DMX_FETCH;
        end
      end
      DMX_MOVE_WAIT: begin
        if (is_move_dst) begin
          cur_next.illegal_dest = dst_protected;
          if (!dst_protected) begin
            cur_next.copy_byte = src_byte;
            if (dst_is_work) begin
              cur_next.work_reg = src_byte;
            end else begin
              mem.we = 1'b1;
              mem.waddr = dst_addr;
              mem.wdata = src_byte;
            end
          end
          cur_next.state = DMX_FETCH;
        end else begin
          // other words ignored, move stays pending
          cur_next.state = DMX_MOVE_WAIT;
        end
      end
      default: begin
        cur_next.state = DMX_FETCH;
      end
    endcase
    if (!rst_n_i) begin
      cur_next.state = DMX_FETCH;
      cur_next.bank_select_reg = DMX_BANK_RST;
      cur_next.work_reg = DMX_WORK_RST;
      cur_next.move_src = DMX_SRC_RST;
      cur_next.copy_byte = DMX_COPY_RST;
      cur_next.illegal_dest = 1'b0;
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge core_clk_i) begin
    cur_reg <= cur_next;
  end

  // ==================================================
  // outputs
  assign ready_o = 1'b1;
  assign bank_select_o = cur_reg.bank_select_reg;
  assign work_o = cur_reg.work_reg;
  assign illegal_dest_o = cur_reg.illegal_dest;
  assign mem_rdata_o = cur_reg.copy_byte;
endmodule

// ===== hw/dmx_pkg.sv
// dmx_pkg: constants and carriers for the data-move execution unit
// assumes a 16-bit instruction word and a 12-bit byte data space
package dmx_pkg;
  // ==================================================
  // widths
  localparam int DMX_ADDR_W = 12;
  localparam int DMX_DATA_W = 8;
  localparam int DMX_DEPTH = 4096;
  // ==================================================
  // opcode fields
  localparam logic [7:0] DMX_OP_BANK_LIT = 8'h01;
  localparam logic [7:0] DMX_OP_WORK_LIT = 8'h0E;
  localparam logic [6:0] DMX_OP_STORE_WORK = 7'h37;
  localparam logic [3:0] DMX_OP_MOVE_SRC = 4'hC;
  localparam logic [3:0] DMX_OP_MOVE_DST = 4'hF;
  localparam int DMX_ABIT_POS = 8;
  // ==================================================
  // special locations and resets
  localparam logic [11:0] DMX_WORK_ADDR = 12'hFE8;
  localparam logic [11:0] DMX_PCL_ADDR = 12'hFF9;
  localparam logic [11:0] DMX_RET_STACK_TOP_LOW_ADDR = 12'hFFD;
  localparam logic [11:0] DMX_RET_STACK_TOP_HIGH_ADDR = 12'hFFE;
  localparam logic [11:0] DMX_RET_STACK_TOP_UPPER_ADDR = 12'hFFF;
  localparam logic [7:0] DMX_ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] DMX_INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] DMX_ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] DMX_BANK_RST = 8'h00;
  localparam logic [7:0] DMX_WORK_RST = 8'h00;
  localparam logic [3:0] DMX_BANK_MASK_HI = 4'h0;
  localparam logic [11:0] DMX_SRC_RST = 12'h000;
  localparam logic [7:0] DMX_COPY_RST = 8'h00;

  typedef enum logic [1:0] {
    DMX_FETCH,
    DMX_MOVE_WAIT
  } dmx_state_e;

  typedef struct packed {
    logic we;
    logic [11:0] waddr;
    logic [7:0] wdata;
    logic [11:0] raddr;
  } dmx_mem_s;

  typedef struct packed {
    dmx_state_e state;
    logic [7:0] bank_select_reg;
    logic [7:0] work_reg;
    logic [11:0] move_src;
    logic [7:0] copy_byte;
    logic illegal_dest;
  } dmx_state_s;
endpackage
